//--- hdl/mpr_sequencer.sv
// Power-off and reset sequencer of the modem core.
// Assumes the host keeps its side of the reset pin and power-up input;
// the command decoder supplies one-cycle command pulses and done levels.
`timescale 1ns/1ps
module mpr_sequencer
  import mpr_pkg::*;
#(
  parameter int unsigned HW_MIN_CYC = HW_RESET_MIN_CYC,
  parameter int unsigned PWRUP_MIN_CYC = PWR_UP_MIN_CYC,
  parameter int unsigned PULSE_CYC = INT_PULSE_CYC,
  parameter int unsigned STEP_CYC = REG_STEP_CYC,
  parameter int unsigned HOLD_CYC = BOOT_HOLD_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic powerDownCmd,
  input wire logic funcResetCmd,
  output logic cmdOk,
  input wire logic underVoltage,
  input wire logic power_up_request_in,
  input wire logic rtcAlarm,
  input wire logic chargerDetect,
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  output logic saveReq,
  input wire logic saveDone,
  output logic detachReq,
  input wire logic detachDone,
  output logic padTristate,
  output logic [NUM_REGS-1:0] regulatorEn,
  output logic backup_supply,
  output logic coreResetN
);
  mpr_state_t state_reg;
  mpr_state_t state_next;
  logic [CNT_W-1:0] timer_reg;
  logic [NUM_REGS-1:0] regs_reg;
  logic pinSync1_reg;
  logic pinSync2_reg;
  logic hwReq;
  logic hwSeen_reg;
  logic pwrUpQual;
  logic resetAfterSave_reg;
  logic timerDone;
  logic wake;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin sampling and qualification

  // Two stages guard against a slow edge through the pin's diode
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pinSync1_reg <= 1'b1;
      pinSync2_reg <= 1'b1;
    end else begin
      pinSync1_reg <= resetPinIn;
      pinSync2_reg <= pinSync1_reg;
    end
  end

  // Own pull-down is masked so only a host-forced low is timed
  mpr_low_timer #(.MIN_CYC(HW_MIN_CYC), .W(CNT_W)) u_hw_timer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .levelN(pinSync2_reg | resetPinOe),
    .qualified(hwReq)
  );

  // Power-up input qualifier; a short low or bare edge does nothing
  mpr_low_timer #(.MIN_CYC(PWRUP_MIN_CYC), .W(CNT_W)) u_pwr_timer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .levelN(power_up_request_in),
    .qualified(pwrUpQual)
  );

  assign wake = pwrUpQual | rtcAlarm | chargerDetect;
  assign timerDone = (timer_reg == '0);

  ////////////////////////////////////////////////////////////////////////////
  // State register and per-state timer

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg <= MPR_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Timer loads on state entry and counts down to zero
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      timer_reg <= '0;
    end else if (state_next != state_reg) begin
      unique case (state_next)
        MPR_INT_PULSE: timer_reg <= CNT_W'(PULSE_CYC - 1);
        MPR_BOOT_HOLD: timer_reg <= CNT_W'(HOLD_CYC - 1);
        default: timer_reg <= CNT_W'(STEP_CYC - 1);
      endcase
    end else if (!timerDone) begin
      timer_reg <= timer_reg - 1'b1;
    end else if (state_reg == MPR_REG_UP || state_reg == MPR_REG_DOWN) begin
      timer_reg <= CNT_W'(STEP_CYC - 1);
    end
  end

  // Remembers that the routine ends in a reset rather than power-off
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      resetAfterSave_reg <= 1'b0;
    end else if (state_reg == MPR_RUN && funcResetCmd) begin
      resetAfterSave_reg <= 1'b1;
    end else if (state_reg == MPR_RUN && powerDownCmd) begin
      resetAfterSave_reg <= 1'b0;
    end
  end

  // A hardware reset is acted on once, on the qualification edge
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      hwSeen_reg <= 1'b0;
    end else begin
      hwSeen_reg <= hwReq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      MPR_OFF: begin
        if (wake && !underVoltage) begin
          state_next = MPR_REG_UP;
        end
      end
      MPR_REG_UP: begin
        if (regs_reg == '1 && timerDone) begin
          state_next = MPR_BOOT_HOLD;
        end
      end
      MPR_BOOT_HOLD: begin
        if (timerDone) begin
          state_next = MPR_RUN;
        end
      end
      MPR_RUN: begin
        if (powerDownCmd || funcResetCmd) begin
          state_next = MPR_SAVE;
        end
      end
      MPR_SAVE: begin
        if (saveDone) begin
          state_next = MPR_DETACH;
        end
      end
      MPR_DETACH: begin
        if (detachDone) begin
          state_next = resetAfterSave_reg ? MPR_INT_PULSE : MPR_REG_DOWN;
        end
      end
      MPR_REG_DOWN: begin
        if (regs_reg == '0 && timerDone) begin
          state_next = MPR_OFF;
        end
      end
      MPR_INT_PULSE: begin
        if (timerDone) begin
          state_next = MPR_BOOT_HOLD;
        end
      end
      MPR_HW_RESET: begin
        if (pinSync2_reg) begin
          state_next = MPR_BOOT_HOLD;
        end
      end
    endcase
    // Under-voltage skips save and detach entirely
    if (underVoltage && state_reg != MPR_OFF && state_reg != MPR_REG_DOWN) begin
      state_next = MPR_REG_DOWN;
    end else if (hwReq && !hwSeen_reg && state_reg != MPR_OFF &&
                 state_reg != MPR_REG_DOWN) begin
      state_next = MPR_HW_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Regulators, one step per timer expiry

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      regs_reg <= '0;
    end else if (timerDone && state_reg == MPR_REG_UP) begin
      regs_reg <= {regs_reg[NUM_REGS-2:0], 1'b1};
    end else if (timerDone && state_reg == MPR_REG_DOWN) begin
      regs_reg <= {1'b0, regs_reg[NUM_REGS-1:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // OK answer is a one-cycle pulse on command acceptance
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cmdOk <= 1'b0;
    end else begin
      cmdOk <= (state_reg == MPR_RUN) && (powerDownCmd || funcResetCmd)
               && !underVoltage;
    end
  end

  // Open drain: output level is always low, enable pulls the line.
  // Released while running and during the routine, when the module is
  // still on, and while the host holds it, or its release is never seen.
  assign resetPinOut = 1'b0;
  assign resetPinOe = (state_reg != MPR_RUN) &&
                      (state_reg != MPR_SAVE) &&
                      (state_reg != MPR_DETACH) &&
                      (state_reg != MPR_HW_RESET);
  assign saveReq = (state_reg == MPR_SAVE);
  assign detachReq = (state_reg == MPR_DETACH);
  // Pads float from the routine start until start-up configuration
  assign padTristate = (state_reg != MPR_RUN) &&
                       (state_reg != MPR_BOOT_HOLD);
  assign regulatorEn = regs_reg;
  assign backup_supply = 1'b1;
  assign coreResetN = (state_reg == MPR_RUN);
endmodule

//--- hdl/mpr_pkg.sv
// Package for the power-off and reset sequencer.
// Assumes a single 10 MHz system clock; all times become cycle counts here.
package mpr_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  // Least low time of the reset pin that counts as a hardware reset
  localparam int unsigned HW_RESET_MIN_MS = 50;
  localparam int unsigned HW_RESET_MIN_CYC =
    (HW_RESET_MIN_MS * CLK_HZ + 999) / 1000;
  // Internal reset indication pulse width
  localparam int unsigned INT_PULSE_US = 160;
  localparam int unsigned INT_PULSE_CYC =
    (INT_PULSE_US * CLK_HZ + 999_999) / 1_000_000;
  // Least low time on the power-up request input
  localparam int unsigned PWR_UP_MIN_MS = 5;
  localparam int unsigned PWR_UP_MIN_CYC =
    (PWR_UP_MIN_MS * CLK_HZ + 999) / 1000;
  // Default times of our own for regulator ramp and start-up hold
  localparam int unsigned REG_STEP_CYC = 16;
  localparam int unsigned BOOT_HOLD_CYC = 64;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned NUM_REGS = 4;
  typedef enum logic [3:0] {
    MPR_OFF, MPR_REG_UP, MPR_BOOT_HOLD, MPR_RUN, MPR_SAVE, MPR_DETACH,
    MPR_REG_DOWN, MPR_INT_PULSE, MPR_HW_RESET
  } mpr_state_t;
endpackage

//--- hdl/mpr_low_timer.sv
// Low-time qualifier: counts consecutive cycles of a low input.
// Assumes the input is already synchronous to sys_clk.
`timescale 1ns/1ps
module mpr_low_timer #(
  parameter int unsigned MIN_CYC = 16,
  parameter int unsigned W = 20
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic levelN,
  output logic qualified
);
  logic [W-1:0] count_reg;

  // Saturating counter; any high cycle restarts it
  always_ff @(posedge sys_clk) begin
    if (!nrst || levelN) begin
      count_reg <= '0;
    end else if (count_reg != W'(MIN_CYC)) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign qualified = (count_reg == W'(MIN_CYC));
endmodule

//--- tb/mpr_seq_monitor.sv
// Port checker for the power-off and reset sequencer.
// Assumes it is bound to mpr_sequencer; one clock, sync active-low reset.
`timescale 1ns/1ps
module mpr_seq_monitor
  import mpr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic powerDownCmd,
  input wire logic funcResetCmd,
  input wire logic cmdOk,
  input wire logic underVoltage,
  input wire logic resetPinIn,
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  input wire logic saveReq,
  input wire logic detachReq,
  input wire logic padTristate,
  input wire logic [NUM_REGS-1:0] regulatorEn,
  input wire logic backup_supply,
  input wire logic coreResetN
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  // Commands count only while running and the supply is good
  sequence s_accept;
    (powerDownCmd || funcResetCmd) && coreResetN && !underVoltage;
  endsequence
  sequence s_uvRun;
    underVoltage && coreResetN;
  endsequence
  property p_ok; s_accept |=> cmdOk; endproperty
  property p_okSave; cmdOk |-> saveReq; endproperty
  property p_refuse; !coreResetN |=> !cmdOk; endproperty
  // Pin is pulled except in run and the routine; a host-held reset may
  // leave it free until the release has crossed the two sync stages
  property p_pin;
    !resetPinOut && !(resetPinOe && (coreResetN || saveReq || detachReq)) &&
    (resetPinOe || coreResetN || saveReq || detachReq ||
     !$past(resetPinIn, 3));
  endproperty
  property p_backup; backup_supply; endproperty
  property p_run; coreResetN |-> !padTristate && (&regulatorEn); endproperty
  // Brown-out must skip the save and detach steps entirely
  property p_uv;
    s_uvRun |=> (!coreResetN && !saveReq && !detachReq) [*3];
  endproperty
  property p_therm; ((regulatorEn + 1'b1) & regulatorEn) == 0; endproperty
  a_ok: assert property (p_ok) else $error("no OK after command");
  a_okSave: assert property (p_okSave)
    else $error("OK without save step");
  a_refuse: assert property (p_refuse)
    else $error("OK given outside run");
  a_pin: assert property (p_pin)
    else $error("reset pin drive wrong");
  a_backup: assert property (p_backup)
    else $error("backup supply dropped");
  a_run: assert property (p_run)
    else $error("run with pads off or regulators down");
  a_uv: assert property (p_uv)
    else $error("brown-out did not shut down cleanly");
  a_therm: assert property (p_therm)
    else $error("regulators out of order");
endmodule

bind mpr_sequencer mpr_seq_monitor u_mon (.sys_clk, .nrst, .powerDownCmd,
  .funcResetCmd, .cmdOk, .underVoltage, .resetPinIn, .resetPinOut,
  .resetPinOe, .saveReq, .detachReq, .padTristate, .regulatorEn,
  .backup_supply, .coreResetN);

//--- tb/mpr_host_model.sv
// Host side of the reset pin: open-drain driver, no pull-up of its own.
// Assumes the module's enable means it pulls the pin low.
`timescale 1ns/1ps
module mpr_host_model (
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  input wire logic holdLow,
  output logic resetPinIn
);
  // Wired-AND over the internal pull-up; host only ever sinks the line
  // Never drives high; while the module is off its enable holds the line low
  assign resetPinIn = !(resetPinOe && !resetPinOut) && !holdLow;
endmodule

//--- tb/testbench.sv
// Self-checking bench for the power-off and reset sequencer.
// Assumes shortened counts; the host model closes the reset pin wire.
`timescale 1ns/1ps
module testbench;
  import mpr_pkg::*;
  localparam int HW = 8, PU = 4, PL = 8;
  logic sys_clk = 0, nrst = 0, powerDownCmd = 0, funcResetCmd = 0;
  logic underVoltage = 0, power_up_request_in = 1, rtcAlarm = 0;
  logic chargerDetect = 0, saveDone = 0, detachDone = 0, holdLow = 0;
  logic cmdOk, resetPinOut, resetPinOe, resetPinIn, saveReq, detachReq;
  logic padTristate, backup_supply, coreResetN;
  logic [NUM_REGS-1:0] regulatorEn;
  int fails = 0, tests_run = 0, n, lowCnt;
  int seed = 32'hecc0_0abb;
  mpr_sequencer #(.HW_MIN_CYC(HW), .PWRUP_MIN_CYC(PU), .PULSE_CYC(PL)) DUT (
    .sys_clk, .nrst, .powerDownCmd, .funcResetCmd, .cmdOk, .underVoltage,
    .power_up_request_in, .rtcAlarm, .chargerDetect, .resetPinIn,
    .resetPinOut, .resetPinOe, .saveReq, .saveDone, .detachReq, .detachDone,
    .padTristate, .regulatorEn, .backup_supply, .coreResetN);
  mpr_host_model host (.resetPinOut, .resetPinOe, .holdLow, .resetPinIn);
  always #50 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded wait for the run state
  task automatic waitRun();
    for (n = 0; n < 600 && coreResetN !== 1'b1; n++) @(posedge sys_clk);
  endtask
  // One-cycle command pulse, sampled at the second edge
  task automatic cmd(input bit pd);
    @(posedge sys_clk);
    powerDownCmd <= pd;
    funcResetCmd <= !pd;
    @(posedge sys_clk);
    powerDownCmd <= 0;
    funcResetCmd <= 0;
    #1;
  endtask
  // Storage and network answer after random delays
  task automatic serve();
    repeat ($random(seed) & 7) @(posedge sys_clk);
    saveDone <= 1;
    for (n = 0; n < 20 && detachReq !== 1'b1; n++) @(posedge sys_clk);
    saveDone <= 0;
    repeat ($random(seed) & 7) @(posedge sys_clk);
    detachDone <= 1;
    for (n = 0; n < 20 && detachReq === 1'b1; n++) @(posedge sys_clk);
    detachDone <= 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1;
    // Cold start through the power-up request, held past its minimum
    power_up_request_in <= 0;
    repeat (PU + 4) @(posedge sys_clk);
    power_up_request_in <= 1;
    waitRun();
    chk("boot", 1, coreResetN);
    chk("pinHigh", 1, resetPinIn);
    $display("startup test done");
    cmd(0);
    chk("okReset", 1, cmdOk);
    chk("pinRoutine", 1, resetPinIn);
    serve();
    for (lowCnt = 0; lowCnt < 600 && resetPinIn !== 1'b1; lowCnt++)
      @(posedge sys_clk);
    chk("pulseLen", 1, lowCnt >= PL + HOLD_CYC_TB());
    chk("resetBack", 1, coreResetN);
    $display("soft reset test done");
    for (int k = 0; k < 3; k++) begin
      cmd(1);
      chk("okOff", 1, cmdOk);
      serve();
      repeat (100) @(posedge sys_clk);
      chk("regsOff", 1, regulatorEn === 4'h0);
      chk("pinLow", 0, resetPinIn);
      cmd(1);
      chk("refused", 0, cmdOk);
      chk("staysOff", 0, coreResetN);
      {chargerDetect, rtcAlarm} <= (k == 2) ? 2'b10 : (k == 1) ? 2'b01 : 2'b00;
      power_up_request_in <= (k != 0);
      repeat (PU + 4) @(posedge sys_clk);
      {chargerDetect, rtcAlarm, power_up_request_in} <= 3'b001;
      waitRun();
      chk("wake", 1, coreResetN);
    end
    $display("power-off test done");
    holdLow <= 1;
    repeat (HW - 4) @(posedge sys_clk);
    holdLow <= 0;
    repeat (4) @(posedge sys_clk);
    chk("shortLow", 1, coreResetN);
    holdLow <= 1;
    repeat (HW + 10) @(posedge sys_clk);
    chk("hwReset", 0, coreResetN);
    chk("noSave", 0, saveReq);
    holdLow <= 0;
    waitRun();
    chk("restart", 1, coreResetN);
    $display("hardware reset test done");
    underVoltage <= 1;
    repeat (100) @(posedge sys_clk);
    chk("uvRegs", 1, regulatorEn === 4'h0);
    chk("uvNoSave", 0, saveReq);
    $display("brown-out test done");
    report_and_stop();
  end
  // Hold-time of the boot phase as set in the design's defaults
  function automatic int HOLD_CYC_TB();
    return BOOT_HOLD_CYC;
  endfunction
  // Watchdog well beyond the fewer than 1500 cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    report_and_stop();
  end
endmodule
